// [dv/itrb_host_bfm.sv]
// Purpose: host processor model on the byte-wide port
// Assumes: write strobe held 5 clk, read strobes 6 clk, address and data 2 clk past release
// Notes:   data_in shows the inverse of the last byte once released
`timescale 1ns/1ns
module itrb_host_bfm (
    input  wire logic       clk,
    output logic            cs_b,
    output logic            rd_b,
    output logic            wr_b,
    output logic            port_select_hi,
    output logic            port_select_lo,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    initial begin
        {cs_b, rd_b, wr_b} = 3'h7;
        {port_select_hi, port_select_lo} = 2'h0;
        data_in = 8'h00;
    end

    task automatic wr(input logic [1:0] adr, input logic [7:0] dat);
        @(posedge clk);
        #1;
        {port_select_hi, port_select_lo} = adr;
        data_in = dat;
        {cs_b, wr_b} = 2'h0;
        repeat (5) @(posedge clk);
        #1;
        wr_b = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        cs_b = 1'b1;
        data_in = ~dat;
        repeat (5) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [1:0] adr, output logic [7:0] dat, output logic ok);
        @(posedge clk);
        #1;
        {port_select_hi, port_select_lo} = adr;
        {cs_b, rd_b} = 2'h0;
        repeat (6) @(posedge clk);
        #1;
        ok = data_oe;
        dat = data_out;
        {cs_b, rd_b} = 2'h3;
        repeat (6) @(posedge clk);
    endtask : rd
endmodule : itrb_host_bfm

// [dv/itrb_tb.sv]
// Purpose: self-checking bench for the interval timer
// Assumes: host model drives the port, bench drives counter pins
// Notes:   counter clock pulses are 4 clk high then 5 clk low, with 8 clk low after the last
`timescale 1ns/1ns
module testbench;
    import itrb_pkg::*;
    typedef struct packed {
        logic [1:0] ch;
        logic [7:0] cw;
        logic [7:0] n;
        logic [7:0] wrap;
    } itrb_row_t;
    logic                 clk;
    logic                 rst_b;
    logic                 cs_b;
    logic                 rd_b;
    logic                 wr_b;
    logic                 psel_hi;
    logic                 psel_lo;
    logic [7:0]           din;
    logic [7:0]           dout;
    logic                 oe;
    logic [ITRB_NCTR-1:0] ctr_clk;
    logic [ITRB_NCTR-1:0] ctr_gate;
    logic [ITRB_NCTR-1:0] ctr_out;
    logic [7:0]           d;
    logic                 ok;
    itrb_row_t            r;
    int                   fails = 0;
    int                   cmp_count = 0;
    itrb_row_t rows [3] = '{'{2'h0, 8'h10, 8'h03, 8'hff}, '{2'h1, 8'h50, 8'h02, 8'hff},
                            '{2'h2, 8'h91, 8'h04, 8'h99}};

    itrb_timer i_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
        .port_select_hi(psel_hi), .port_select_lo(psel_lo), .data_in(din), .data_out(dout),
        .data_oe(oe), .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out));
    itrb_host_bfm i_host (.clk(clk), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
        .port_select_hi(psel_hi), .port_select_lo(psel_lo), .data_in(din),
        .data_out(dout), .data_oe(oe));

    always #5 clk = ~clk;

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic rdx(input logic [1:0] adr, input logic [7:0] exp);
        i_host.rd(adr, d, ok);
        check("bus drive", {7'h0, ok}, 8'h01);
        check("read data", d, exp);
    endtask : rdx

    task automatic pulse(input int ch, input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
            ctr_clk[ch] = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            ctr_clk[ch] = 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        ctr_clk = '0;
        ctr_gate = '1;
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check("out rst", {5'h0, ctr_out}, 8'h00);
        check("oe rst", {7'h0, oe}, 8'h00);
        foreach (rows[i]) begin
            r = rows[i];
            i_host.wr(ITRB_ADDR_CTL, r.cw);
            i_host.wr(ITRB_ADDR_CTL, 8'he0 | (8'h2 << r.ch));
            rdx(r.ch, {2'b01, r.cw[5:0]});
            i_host.wr(r.ch, r.n);
            pulse(r.ch, 1);
            i_host.wr(ITRB_ADDR_CTL, 8'hc0 | (8'h2 << r.ch));
            rdx(r.ch, {2'b00, r.cw[5:0]});
            rdx(r.ch, r.n);
            pulse(r.ch, r.n - 1);
            check("out low", {7'h0, ctr_out[r.ch]}, 8'h00);
            pulse(r.ch, 2);
            i_host.wr(ITRB_ADDR_CTL, 8'hc0 | (8'h2 << r.ch));
            rdx(r.ch, {2'b10, r.cw[5:0]});
            rdx(r.ch, r.wrap);
        end
        i_host.rd(ITRB_ADDR_CTL, d, ok);
        check("refused", {7'h0, ok}, 8'h00);
        i_host.wr(ITRB_ADDR_CTL, 8'he2);
        rdx(2'h0, 8'h90);
        i_host.wr(ITRB_ADDR_CTL, 8'ha0);
        i_host.wr(2'h2, 8'h01);
        pulse(2, 1);
        i_host.wr(ITRB_ADDR_CTL, 8'h80);
        pulse(2, 1);
        i_host.wr(ITRB_ADDR_CTL, 8'h80);
        rdx(2'h2, 8'h01);
        rdx(2'h2, 8'h00);
        i_host.wr(ITRB_ADDR_CTL, 8'h70);
        i_host.wr(2'h1, 8'h02);
        i_host.wr(2'h1, 8'h00);
        pulse(1, 3);
        check("out hi", {7'h0, ctr_out[1]}, 8'h01);
        i_host.wr(2'h1, 8'h10);
        check("out lo", {7'h0, ctr_out[1]}, 8'h00);
        pulse(1, 2);
        i_host.wr(ITRB_ADDR_CTL, 8'he4);
        rdx(2'h1, 8'h30);
        i_host.wr(2'h1, 8'h00);
        i_host.wr(ITRB_ADDR_CTL, 8'hc4);
        rdx(2'h1, 8'h70);
        rdx(2'h1, 8'h00);
        rdx(2'h1, 8'h00);
        pulse(1, 3);
        i_host.wr(ITRB_ADDR_CTL, 8'hc4);
        pulse(1, 1);
        i_host.wr(ITRB_ADDR_CTL, 8'hc4);
        rdx(2'h1, 8'h30);
        rdx(2'h1, 8'h0e);
        rdx(2'h1, 8'h00);
        rdx(2'h1, 8'h0d);
        rdx(2'h1, 8'h00);
        #1;
        ctr_gate[0] = 1'b0;
        i_host.wr(ITRB_ADDR_CTL, 8'h10);
        i_host.wr(2'h0, 8'h02);
        pulse(0, 4);
        check("gate lo", {7'h0, ctr_out[0]}, 8'h00);
        #1;
        ctr_gate[0] = 1'b1;
        pulse(0, 1);
        check("gate 1", {7'h0, ctr_out[0]}, 8'h00);
        pulse(0, 1);
        check("gate 2", {7'h0, ctr_out[0]}, 8'h01);
        i_host.wr(2'h0, 8'h03);
        check("new count", {7'h0, ctr_out[0]}, 8'h00);
        pulse(0, 3);
        check("reload lo", {7'h0, ctr_out[0]}, 8'h00);
        pulse(0, 1);
        check("reload hi", {7'h0, ctr_out[0]}, 8'h01);
        end_of_test();
    end
endmodule : testbench

// [dv/itrb_timer_sva.sv]
// Purpose: port-level checks of the interval timer
// Assumes: one clock domain, reset rst_b
// Notes:   output timing checked on counter 0
`timescale 1ns/1ns
module itrb_timer_chk
    import itrb_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 cs_b,
    input wire logic                 rd_b,
    input wire logic                 wr_b,
    input wire logic                 port_select_hi,
    input wire logic                 port_select_lo,
    input wire logic [7:0]           data_in,
    input wire logic [7:0]           data_out,
    input wire logic                 data_oe,
    input wire logic [ITRB_NCTR-1:0] ctr_clk,
    input wire logic [ITRB_NCTR-1:0] ctr_gate,
    input wire logic [ITRB_NCTR-1:0] ctr_out
);
    logic rd_req;
    logic wr_req;
    assign rd_req = !cs_b && !rd_b && wr_b && {port_select_hi, port_select_lo} != ITRB_ADDR_CTL;
    assign wr_req = !cs_b && !wr_b && rd_b;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_cw_zero;
        (wr_req && {port_select_hi, port_select_lo} == ITRB_ADDR_CTL && data_in == 8'h10) ##1 wr_b;
    endsequence

    a_oe_after_req: assert property ($rose(data_oe) |-> $past(rd_req, 2))
        else $error("bus driven without a read");
    a_oe_release: assert property ($fell(data_oe) |-> !$past(rd_req, 2))
        else $error("bus released during a read");
    a_oe_refused: assert property ((!rd_req) [*6] |-> !data_oe)
        else $error("bus driven while idle");
    a_oe_grant: assert property (rd_req [*6] |-> data_oe)
        else $error("read not answered");
    a_wr_no_oe: assert property (wr_req [*4] |-> !data_oe)
        else $error("bus driven during a write");
    a_cw_out_low: assert property (s_cw_zero |-> ##6 !ctr_out[0])
        else $error("output high after control word");
    a_gate_hold: assert property ((!ctr_gate[0]) [*8] |-> !$rose(ctr_out[0]))
        else $error("output rose with gate low");
    a_clk_low_hold: assert property ((!ctr_clk[0]) [*8] |-> !$rose(ctr_out[0]))
        else $error("output rose without clock fall");
endmodule : itrb_timer_chk

bind itrb_timer itrb_timer_chk i_chk (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
    .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out)
);

// [hdl/itrb_pkg.sv]
// Purpose: shared constants and types for the three-channel interval timer
// Assumes: byte-wide host port, 16-bit counters
// Notes:   control word field positions and status byte layout
package itrb_pkg;
    localparam int        ITRB_NCTR        = 3;
    localparam logic [1:0] ITRB_ADDR_CTL   = 2'h3;
    localparam logic [1:0] ITRB_SEL_RDBK   = 2'h3;
    localparam logic [1:0] ITRB_RW_LATCH   = 2'h0;
    localparam logic [1:0] ITRB_RW_LSB     = 2'h1;
    localparam logic [1:0] ITRB_RW_MSB     = 2'h2;
    localparam logic [1:0] ITRB_RW_BOTH    = 2'h3;
    localparam logic [2:0] ITRB_MODE_ZERO  = 3'h0;
    localparam int        ITRB_CW_SEL_HI   = 7;
    localparam int        ITRB_CW_SEL_LO   = 6;
    localparam int        ITRB_RB_CNT_BIT  = 5;
    localparam int        ITRB_RB_STS_BIT  = 4;
    localparam int        ITRB_RB_SEL_LO   = 1;
    localparam logic [15:0] ITRB_BIN_MAX   = 16'hffff;
    localparam logic [15:0] ITRB_BCD_MAX   = 16'h9999;
    localparam logic [15:0] ITRB_RST_COUNT = 16'h0000;
    localparam logic [7:0]  ITRB_RST_BYTE  = 8'h00;

    typedef struct packed {
        logic [1:0] byte_access_sel;
        logic [2:0] mode_sel;
        logic       bcd;
    } itrb_mode_t;

    typedef struct packed {
        logic       out_level;
        logic       null_count;
        itrb_mode_t mode;
    } itrb_status_t;
endpackage : itrb_pkg

// [hdl/itrb_timer.sv]
// Purpose: host port, read-back, status and mode-zero counting for three counters
// Assumes: host strobes and counter pins are asynchronous to clk
// Notes:   modes other than zero hold the counting element still
`timescale 1ns/1ns
module itrb_timer
    import itrb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 cs_b,
    input  wire logic                 rd_b,
    input  wire logic                 wr_b,
    input  wire logic                 port_select_hi,
    input  wire logic                 port_select_lo,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic                      data_oe,
    input  wire logic [ITRB_NCTR-1:0] ctr_clk,
    input  wire logic [ITRB_NCTR-1:0] ctr_gate,
    output logic      [ITRB_NCTR-1:0] ctr_out
);
    // bcd-aware decrement with wrap
    function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v - 16'h0001;
        if (bcd) begin
            if (v == ITRB_RST_COUNT) r = ITRB_BCD_MAX;
            else if (v[11:0] == 12'h000) r = {v[15:12] - 4'h1, 12'h999};
            else if (v[7:0] == 8'h00) r = {v[15:8] - 8'h01, 8'h99};
            else if (v[3:0] == 4'h0) r = {v[15:4] - 12'h001, 4'h9};
        end else if (v == ITRB_RST_COUNT) begin
            r = ITRB_BIN_MAX;
        end
        return r;
    endfunction : dec_count

    // two-flop synchronisers for all asynchronous inputs
    logic [2:0]  hs1_ff, hs2_ff;
    logic [1:0]  as1_ff, as2_ff;
    logic [7:0]  ds1_ff, ds2_ff;
    logic [ITRB_NCTR-1:0] ck1_ff, ck2_ff, ck3_ff, gt1_ff, gt2_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs1_ff <= 3'h7;
            hs2_ff <= 3'h7;
            as1_ff <= 2'h0;
            as2_ff <= 2'h0;
            ds1_ff <= ITRB_RST_BYTE;
            ds2_ff <= ITRB_RST_BYTE;
            ck1_ff <= '0;
            ck2_ff <= '0;
            ck3_ff <= '0;
            gt1_ff <= '0;
            gt2_ff <= '0;
        end else begin
            hs1_ff <= {cs_b, rd_b, wr_b};
            hs2_ff <= hs1_ff;
            as1_ff <= {port_select_hi, port_select_lo};
            as2_ff <= as1_ff;
            ds1_ff <= data_in;
            ds2_ff <= ds1_ff;
            ck1_ff <= ctr_clk;
            ck2_ff <= ck1_ff;
            ck3_ff <= ck2_ff;
            gt1_ff <= ctr_gate;
            gt2_ff <= gt1_ff;
        end
    end

    logic       wr_prev_ff, rd_prev_ff;
    logic       wr_act, rd_act, wr_done, rd_done;
    logic [ITRB_NCTR-1:0] clk_fall;
    // strobes act when asserted alone with chip select, reads only off the control address; events at strobe release
    assign wr_act   = !hs2_ff[2] && !hs2_ff[0] && hs2_ff[1];
    assign rd_act   = !hs2_ff[2] && !hs2_ff[1] && hs2_ff[0]
                      && (as2_ff != ITRB_ADDR_CTL);
    assign wr_done  = wr_prev_ff && !wr_act;
    assign rd_done  = rd_prev_ff && !rd_act;
    assign clk_fall = ck3_ff & ~ck2_ff;

    logic [1:0] wr_addr_ff, rd_addr_ff;
    logic [7:0] wr_data_ff;

    itrb_mode_t            mode_ff     [ITRB_NCTR];
    logic [15:0]           ce_ff       [ITRB_NCTR];
    logic [15:0]           cr_ff       [ITRB_NCTR];
    logic [15:0]           count_hold_latch_ff [ITRB_NCTR];
    logic [7:0]            sts_hold_ff [ITRB_NCTR];
    logic [ITRB_NCTR-1:0]  cnt_lat_ff, sts_lat_ff, null_ff, load_pend_ff, cnt_en_ff;
    logic [ITRB_NCTR-1:0]  wr_msb_ff, rd_msb_ff, out_ff;
    logic [7:0]            dout_ff;
    logic                  oe_ff;

    itrb_mode_t            nxt_mode     [ITRB_NCTR];
    logic [15:0]           nxt_ce       [ITRB_NCTR];
    logic [15:0]           nxt_cr       [ITRB_NCTR];
    logic [15:0]           nxt_count_hold_latch [ITRB_NCTR];
    logic [7:0]            nxt_sts_hold [ITRB_NCTR];
    logic [ITRB_NCTR-1:0]  nxt_cnt_lat, nxt_sts_lat, nxt_null, nxt_load_pend, nxt_cnt_en;
    logic [ITRB_NCTR-1:0]  nxt_wr_msb, nxt_rd_msb, nxt_out;
    logic [7:0]            nxt_dout;

    always_comb begin
        logic [15:0]  rd_val;
        itrb_status_t st;
        int           w;
        int           r;
        rd_val = ITRB_RST_COUNT;
        st = '0;
        w = int'(wr_addr_ff);
        r = int'(rd_addr_ff);
        nxt_mode = mode_ff;
        nxt_ce = ce_ff;
        nxt_cr = cr_ff;
        nxt_count_hold_latch = count_hold_latch_ff;
        nxt_sts_hold = sts_hold_ff;
        nxt_cnt_lat = cnt_lat_ff;
        nxt_sts_lat = sts_lat_ff;
        nxt_null = null_ff;
        nxt_load_pend = load_pend_ff;
        nxt_cnt_en = cnt_en_ff;
        nxt_wr_msb = wr_msb_ff;
        nxt_rd_msb = rd_msb_ff;
        nxt_out = out_ff;
        nxt_dout = dout_ff;
        // counting element: falling edge of each counter clock
        for (int i = 0; i < ITRB_NCTR; i++) begin
            if (clk_fall[i] && mode_ff[i].mode_sel == ITRB_MODE_ZERO) begin
                if (load_pend_ff[i]) begin
                    nxt_ce[i] = cr_ff[i];
                    nxt_null[i] = 1'b0;
                    nxt_load_pend[i] = 1'b0;
                    nxt_cnt_en[i] = 1'b1;
                end else if (cnt_en_ff[i] && gt2_ff[i]) begin
                    nxt_ce[i] = dec_count(ce_ff[i], mode_ff[i].bcd);
                    if (ce_ff[i] == 16'h0001) nxt_out[i] = 1'b1;
                end
            end
            // live latch follows the element while not held
            if (!cnt_lat_ff[i]) nxt_count_hold_latch[i] = nxt_ce[i];
        end
        // host read: status first, then count bytes
        if (rd_done && r < ITRB_NCTR) begin
            if (sts_lat_ff[r]) begin
                nxt_sts_lat[r] = 1'b0;
            end else begin
                if (mode_ff[r].byte_access_sel != ITRB_RW_BOTH || rd_msb_ff[r])
                    nxt_cnt_lat[r] = 1'b0;
                if (mode_ff[r].byte_access_sel == ITRB_RW_BOTH)
                    nxt_rd_msb[r] = !rd_msb_ff[r];
            end
        end
        // host write
        if (wr_done) begin
            if (wr_addr_ff == ITRB_ADDR_CTL) begin
                if (wr_data_ff[ITRB_CW_SEL_HI:ITRB_CW_SEL_LO] == ITRB_SEL_RDBK) begin
                    for (int i = 0; i < ITRB_NCTR; i++) begin
                        if (wr_data_ff[ITRB_RB_SEL_LO + i]) begin
                            if (!wr_data_ff[ITRB_RB_CNT_BIT] && !cnt_lat_ff[i])
                                nxt_cnt_lat[i] = 1'b1;
                            if (!wr_data_ff[ITRB_RB_STS_BIT] && !sts_lat_ff[i]) begin
                                st.out_level = out_ff[i];
                                st.null_count = null_ff[i];
                                st.mode = mode_ff[i];
                                nxt_sts_hold[i] = st;
                                nxt_sts_lat[i] = 1'b1;
                            end
                        end
                    end
                end else begin
                    w = int'(wr_data_ff[ITRB_CW_SEL_HI:ITRB_CW_SEL_LO]);
                    if (wr_data_ff[ITRB_RB_CNT_BIT:ITRB_RB_STS_BIT] == ITRB_RW_LATCH) begin
                        if (!cnt_lat_ff[w]) nxt_cnt_lat[w] = 1'b1;
                    end else begin
                        nxt_mode[w] = wr_data_ff[5:0];
                        nxt_null[w] = 1'b1;
                        nxt_cnt_lat[w] = 1'b0;
                        nxt_sts_lat[w] = 1'b0;
                        nxt_load_pend[w] = 1'b0;
                        nxt_cnt_en[w] = 1'b0;
                        nxt_wr_msb[w] = 1'b0;
                        nxt_rd_msb[w] = 1'b0;
                        nxt_out[w] = 1'b0;
                    end
                end
            end else begin
                case (mode_ff[w].byte_access_sel)
                    ITRB_RW_LSB: begin
                        nxt_cr[w] = {8'h00, wr_data_ff};
                        nxt_null[w] = 1'b1;
                        nxt_load_pend[w] = 1'b1;
                    end
                    ITRB_RW_MSB: begin
                        nxt_cr[w] = {wr_data_ff, 8'h00};
                        nxt_null[w] = 1'b1;
                        nxt_load_pend[w] = 1'b1;
                    end
                    ITRB_RW_BOTH: begin
                        if (!wr_msb_ff[w]) begin
                            nxt_cr[w][7:0] = wr_data_ff;
                            nxt_cnt_en[w] = 1'b0;
                            nxt_load_pend[w] = 1'b0;
                        end else begin
                            nxt_cr[w][15:8] = wr_data_ff;
                            nxt_null[w] = 1'b1;
                            nxt_load_pend[w] = 1'b1;
                        end
                        nxt_wr_msb[w] = !wr_msb_ff[w];
                    end
                    default: begin
                    end
                endcase
                if (mode_ff[w].mode_sel == ITRB_MODE_ZERO
                    && mode_ff[w].byte_access_sel != ITRB_RW_LATCH)
                    nxt_out[w] = 1'b0;
            end
        end
        // read data presented while read strobe is active
        if (r < ITRB_NCTR) begin
            rd_val = count_hold_latch_ff[r];
            if (sts_lat_ff[r]) nxt_dout = sts_hold_ff[r];
            else if (mode_ff[r].byte_access_sel == ITRB_RW_MSB) nxt_dout = rd_val[15:8];
            else if (mode_ff[r].byte_access_sel == ITRB_RW_BOTH && rd_msb_ff[r])
                nxt_dout = rd_val[15:8];
            else nxt_dout = rd_val[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_prev_ff <= 1'b0;
            rd_prev_ff <= 1'b0;
            wr_addr_ff <= 2'h0;
            rd_addr_ff <= 2'h0;
            wr_data_ff <= ITRB_RST_BYTE;
            for (int i = 0; i < ITRB_NCTR; i++) begin
                mode_ff[i] <= '0;
                ce_ff[i] <= ITRB_RST_COUNT;
                cr_ff[i] <= ITRB_RST_COUNT;
                count_hold_latch_ff[i] <= ITRB_RST_COUNT;
                sts_hold_ff[i] <= ITRB_RST_BYTE;
            end
            cnt_lat_ff <= '0;
            sts_lat_ff <= '0;
            null_ff <= '0;
            load_pend_ff <= '0;
            cnt_en_ff <= '0;
            wr_msb_ff <= '0;
            rd_msb_ff <= '0;
            out_ff <= '0;
            dout_ff <= ITRB_RST_BYTE;
            oe_ff <= 1'b0;
        end else begin
            wr_prev_ff <= wr_act;
            rd_prev_ff <= rd_act;
            if (wr_act) wr_addr_ff <= as2_ff;
            if (wr_act) wr_data_ff <= ds2_ff;
            if (rd_act) rd_addr_ff <= as2_ff;
            mode_ff <= nxt_mode;
            ce_ff <= nxt_ce;
            cr_ff <= nxt_cr;
            count_hold_latch_ff <= nxt_count_hold_latch;
            sts_hold_ff <= nxt_sts_hold;
            cnt_lat_ff <= nxt_cnt_lat;
            sts_lat_ff <= nxt_sts_lat;
            null_ff <= nxt_null;
            load_pend_ff <= nxt_load_pend;
            cnt_en_ff <= nxt_cnt_en;
            wr_msb_ff <= nxt_wr_msb;
            rd_msb_ff <= nxt_rd_msb;
            out_ff <= nxt_out;
            dout_ff <= nxt_dout;
            oe_ff <= rd_act;
        end
    end

    assign data_out = dout_ff;
    assign data_oe  = oe_ff;
    assign ctr_out  = out_ff;
endmodule : itrb_timer
